/* hw/gpm_pin_mux.v */
// Shared pin multiplexer between general I/O and primary functions
// Operation
// - Clock pads follow software bits alone, DAC and PCI pads also follow a strap caught once after reset release.
// - Strap-configured pads give at most one peripheral control, PCI or general I/O, never both.
// - After reset bits 1 and 2 carry the two clock outputs since their enables reset to zero.
// - An enable bit at one hands the pad to general I/O instead of its primary function, except on bits 15:8 while PCI is selected.
// - For an enabled pin direction zero makes an input and direction one drives an output.
// - The bit 8 pad carries the video DAC control output by default.
// - Bit 8 reaches its pad only while the PCI select is zero and its enable is set.
// - Bits 15:9 are general I/O only while the PCI select is zero and their enables are set.
// - At reset bits 15:9 have no active function, with enables cleared and PCI select zero.
// - The PCI select, shown at strap status bit 8, picks PCI or the other peripheral group globally.
// - The Ethernet enable at bit 11 keeps Ethernet off when zero and has no effect while PCI is selected.
`timescale 1ns/1ps
`include "gpm_defines.vh"
module gpm_pin_mux (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Strap inputs
  input wire strap_pci_select_i,
  input wire strap_ethernet_enable_i,
  // Software configuration
  input wire [15:0] io_pin_enable_i,
  input wire [15:0] io_pin_direction_i,
  input wire [15:0] general_io_bank_out_i,
  // Primary functions
  input wire clock_output_a_i,
  input wire clock_output_b_i,
  input wire video_dac_control_output_i,
  input wire [6:0] pci_out_i,
  input wire [6:0] pci_oe_i,
  // Pads
  input wire [15:0] pad_in_i,
  output wire [15:0] pad_out_o,
  output wire [15:0] pad_oe_o,
  // Status
  output reg [15:0] general_io_bank_in_o,
  output reg [15:0] io_select_o,
  output reg [15:0] strap_status_o,
  output reg pci_enable_o,
  output reg ethernet_block_enable_o
);
  reg [15:0] enable;
  reg [15:0] direction;
  reg pci_select;
  reg ethernet_enable;
  reg strap_taken;
  reg [15:0] next_select;
  reg [15:0] prim_out;
  reg [15:0] prim_oe;
  integer k;

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      enable <= `GPM_RST_ENABLE;
      direction <= `GPM_RST_DIRECTION;
      pci_select <= `GPM_RST_PCI_SELECT;
      ethernet_enable <= 1'b0;
      strap_taken <= 1'b0;
    end else begin
      enable <= io_pin_enable_i;
      direction <= io_pin_direction_i;
      if (!strap_taken) begin
        pci_select <= strap_pci_select_i;
        ethernet_enable <= strap_ethernet_enable_i;
        strap_taken <= 1'b1;
      end
    end
  end

  always @* begin
    next_select = 16'h0000;
    prim_out = 16'h0000;
    prim_oe = 16'h0000;
    for (k = 0; k < `GPM_IO_WIDTH; k = k + 1) begin
      if (k == `GPM_BIT_CLKA || k == `GPM_BIT_CLKB) begin
        next_select[k] = enable[k];
      end else if (k == `GPM_BIT_DAC) begin
        next_select[k] = enable[k] & ~pci_select;
      end else if (k >= `GPM_PCI_LO) begin
        next_select[k] = enable[k] & ~pci_select;
      end else begin
        next_select[k] = enable[k];
      end
    end
    prim_out[`GPM_BIT_CLKA] = clock_output_a_i;
    prim_oe[`GPM_BIT_CLKA] = 1'b1;
    prim_out[`GPM_BIT_CLKB] = clock_output_b_i;
    prim_oe[`GPM_BIT_CLKB] = 1'b1;
    prim_out[`GPM_BIT_DAC] = video_dac_control_output_i;
    prim_oe[`GPM_BIT_DAC] = 1'b1;
    prim_out[`GPM_PCI_HI:`GPM_PCI_LO] = pci_out_i & {`GPM_PCI_COUNT{pci_select}};
    prim_oe[`GPM_PCI_HI:`GPM_PCI_LO] = pci_oe_i & {`GPM_PCI_COUNT{pci_select}};
  end

  genvar g;
  generate
    for (g = 0; g < `GPM_IO_WIDTH; g = g + 1) begin : pad_g
      gpm_pad_cell u_pad (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .io_select_i(next_select[g]),
        .io_pin_direction_i(direction[g]),
        .io_out_i(general_io_bank_out_i[g]),
        .prim_out_i(prim_out[g]),
        .prim_oe_i(prim_oe[g]),
        .pad_out_o(pad_out_o[g]),
        .pad_oe_o(pad_oe_o[g])
      );
    end
  endgenerate

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      general_io_bank_in_o <= 16'h0000;
      io_select_o <= 16'h0000;
      strap_status_o <= 16'h0000;
      pci_enable_o <= 1'b0;
      ethernet_block_enable_o <= 1'b0;
    end else begin
      general_io_bank_in_o <= pad_in_i & next_select & ~direction;
      io_select_o <= next_select;
      strap_status_o <= 16'h0000;
      strap_status_o[`GPM_STRAP_PCI_POS] <= pci_select;
      strap_status_o[`GPM_STRAP_ETH_POS] <= ethernet_enable;
      pci_enable_o <= pci_select;
      ethernet_block_enable_o <= ethernet_enable & ~pci_select;
    end
  end
endmodule // gpm_pin_mux

/* hw/gpm_defines.vh */
// Constants for the shared pin multiplexer
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH
`define GPM_IO_WIDTH 16
`define GPM_BIT_CLKA 1
`define GPM_BIT_CLKB 2
`define GPM_BIT_DAC 8
`define GPM_PCI_LO 9
`define GPM_PCI_HI 15
`define GPM_PCI_COUNT 7
`define GPM_STRAP_PCI_POS 8
`define GPM_STRAP_ETH_POS 11
`define GPM_RST_ENABLE 16'h0000
`define GPM_RST_DIRECTION 16'h0000
`define GPM_RST_PCI_SELECT 1'h0
`endif

/* hw/gpm_pad_cell.v */
// One shared pad: picks general I/O or primary function
`timescale 1ns/1ps
`include "gpm_defines.vh"
module gpm_pad_cell (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Selection
  input wire io_select_i,
  input wire io_pin_direction_i,
  // General I/O side
  input wire io_out_i,
  // Primary function side
  input wire prim_out_i,
  input wire prim_oe_i,
  // Pad
  output reg pad_out_o,
  output reg pad_oe_o
);
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pad_out_o <= 1'b0;
      pad_oe_o <= 1'b0;
    end else if (io_select_i) begin
      pad_out_o <= io_out_i;
      pad_oe_o <= io_pin_direction_i;
    end else begin
      pad_out_o <= prim_out_i;
      pad_oe_o <= prim_oe_i;
    end
  end
endmodule // gpm_pad_cell

/* verif/gpm_board_model.sv */
// External devices driving the shared pads
`timescale 1ns/1ps
module gpm_board_model (
  input wire [15:0] oe_i, out_i, ext_i,
  output wire [15:0] pad_o
);
  // Devices let go of every pad the mux drives
  assign pad_o = oe_i & out_i | ~oe_i & ext_i;
endmodule // gpm_board_model

/* verif/gpm_pin_mux_properties.sv */
// Port assertions for the shared pin mux
`timescale 1ns/1ps
module gpm_pin_mux_properties (
  input wire clock_i, reset_i, clock_output_a_i, pci_enable_o, ethernet_block_enable_o,
  input wire [15:0] io_pin_enable_i, io_pin_direction_i, pad_out_o, pad_oe_o, io_select_o, strap_status_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence up_s; !reset_i [*4]; endsequence
  sel_map_a: assert property (up_s |-> io_select_o == ($past(io_pin_enable_i, 2) & ~{{8{pci_enable_o}}, 8'h00}))
    else $error("select");
  dir_oe_a: assert property (up_s |-> ((pad_oe_o ^ $past(io_pin_direction_i, 2)) & io_select_o) == 0)
    else $error("direction");
  clk_pad_a: assert property (up_s ##0 !io_select_o[1] |-> pad_out_o[1] == $past(clock_output_a_i))
    else $error("clock pad");
  pci_excl_a: assert property (up_s ##0 pci_enable_o |-> io_select_o[15:8] == 0)
    else $error("exclusive");
  idle_hiz_a: assert property (up_s ##0 !pci_enable_o |-> (pad_oe_o[15:9] & ~io_select_o[15:9]) == 0)
    else $error("idle pads");
  eth_gate_a: assert property (ethernet_block_enable_o |-> !pci_enable_o && strap_status_o[11])
    else $error("ethernet");
  strap_bit_a: assert property (strap_status_o[8] == pci_enable_o)
    else $error("status");
  strap_hold_a: assert property (up_s |-> $stable(strap_status_o))
    else $error("strap");
endmodule // gpm_pin_mux_properties
bind gpm_pin_mux gpm_pin_mux_properties chk_i (.*);

/* verif/gpm_pin_mux_tb.sv */
// Bench for the shared pin mux
`timescale 1ns/1ps
module gpm_pin_mux_tb;
  logic clock_i = 0, reset_i = 1, p, e;
  logic [1:0] st = 0;
  logic [15:0] en = 0, dr = 0, go = 0, pr = 0, ext = 0, s, oe;
  wire pci_enable_o, ethernet_block_enable_o;
  wire [15:0] pad_in_i, pad_out_o, pad_oe_o, general_io_bank_in_o, io_select_o, strap_status_o;
  int err_total = 0, num_checks = 0;
  gpm_pin_mux uut (.*, .strap_pci_select_i(st[1]), .strap_ethernet_enable_i(st[0]), .io_pin_enable_i(en),
    .io_pin_direction_i(dr), .general_io_bank_out_i(go), .clock_output_a_i(pr[1]), .clock_output_b_i(pr[2]),
    .video_dac_control_output_i(pr[8]), .pci_out_i(pr[15:9]), .pci_oe_i(ext[15:9]));
  gpm_board_model brd (.oe_i(pad_oe_o), .out_i(pad_out_o), .ext_i(ext), .pad_o(pad_in_i));
  task chk(input logic [15:0] got, want);
    num_checks++;
    if (got !== want) begin
      err_total++;
      $display("unexpected %0t %h", $time, got);
    end
  endtask
  function automatic logic [15:0] exp_sel(input logic [15:0] en_v, input logic pci);
    return en_v & ~{{8{pci}}, 8'h00};
  endfunction
  task summarize;
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #5 clock_i = ~clock_i;
  initial begin
    #20000 err_total++;
    summarize;
  end
  initial begin
    void'($urandom(77814));
    for (int i = 0; i < 40; i++) begin
      @(posedge clock_i);
      #1 reset_i = 1;
      {dr, go} = $urandom;
      {pr, ext} = $urandom;
      {p, e} = i < 2 ? {i[0], 1'b1} : 2'($urandom);
      en = i < 2 ? 16'hffff : 16'($urandom);
      st = {p, e};
      repeat (6) @(posedge clock_i);
      #1 reset_i = 0;
      repeat (2) @(posedge clock_i);
      #1 st = ~st;
      repeat (3) @(posedge clock_i);
      #1 s = exp_sel(en, p);
      oe = s & dr | ~s & {p ? ext[15:9] : 7'h00, 9'h106};
      chk(io_select_o, s);
      chk(pad_oe_o, oe);
      chk(pad_out_o & oe, oe & (s & go | ~s & pr));
      chk(general_io_bank_in_o, s & ~dr & ext);
      chk(strap_status_o | {pci_enable_o, ethernet_block_enable_o}, {4'h0, e, 2'h0, p, 6'h00, p, e & ~p});
    end
    summarize;
  end
endmodule // gpm_pin_mux_tb
